// ==== psw_pkg.sv ====
// shared constants, register map and types for the preset switching outputs
package psw_pkg;

  // clock and timing
  localparam int unsigned PSW_CLK_HZ         = 100_000_000;
  localparam int unsigned PSW_PULSE_MS       = 500;
  localparam int unsigned PSW_REPORT_MS      = 2000;
  localparam int unsigned PSW_PULSE_CYCLES   = PSW_CLK_HZ / 1000 * PSW_PULSE_MS;
  localparam int unsigned PSW_REPORT_CYCLES  = PSW_CLK_HZ / 1000 * PSW_REPORT_MS;
  localparam int unsigned PSW_TIMER_W        = 28;

  // register byte offsets
  localparam logic [7:0] PSW_OFS_CTRL    = 8'h00;
  localparam logic [7:0] PSW_OFS_HYST1   = 8'h04;
  localparam logic [7:0] PSW_OFS_HYST2   = 8'h08;
  localparam logic [7:0] PSW_OFS_THR1    = 8'h0c;
  localparam logic [7:0] PSW_OFS_THR2    = 8'h10;
  localparam logic [7:0] PSW_OFS_STATUS  = 8'h14;
  localparam logic [7:0] PSW_OFS_DISPLAY = 8'h18;

  // field positions
  localparam int unsigned PSW_CTRL_C1_LSB   = 0;
  localparam int unsigned PSW_CTRL_C2_LSB   = 4;
  localparam int unsigned PSW_ST_OUT1       = 0;
  localparam int unsigned PSW_ST_OUT2       = 1;
  localparam int unsigned PSW_ST_REP_ACTIVE = 2;
  localparam int unsigned PSW_ST_REP_LSB    = 4;
  localparam int unsigned PSW_HYST_W        = 14;

  // reset values and limits
  localparam logic [31:0] PSW_THR1_RESET = 32'h0000_2710;
  localparam logic [31:0] PSW_THR2_RESET = 32'h0000_1388;
  localparam logic [13:0] PSW_HYST_RESET = 14'h0000;
  localparam logic [31:0] PSW_HYST_MAX   = 32'h0000_270f;

  // axi responses
  localparam logic [1:0] PSW_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PSW_RESP_SLVERR = 2'h2;

  // switching characteristics; trailing codes are legal for output 2 only
  typedef enum logic [2:0] {
    PSW_CHAR_STATIC_GE  = 3'h0,
    PSW_CHAR_STATIC_LT  = 3'h1,
    PSW_CHAR_DYN_GE     = 3'h2,
    PSW_CHAR_DYN_LT     = 3'h3,
    PSW_CHAR_TRAIL_STAT = 3'h4,
    PSW_CHAR_TRAIL_DYN  = 3'h5
  } psw_char_type;

  // output state report codes, {output2, output1}
  localparam logic [1:0] PSW_REP_BOTH_OFF = 2'h0;
  localparam logic [1:0] PSW_REP_ONLY_1   = 2'h1;
  localparam logic [1:0] PSW_REP_ONLY_2   = 2'h2;
  localparam logic [1:0] PSW_REP_BOTH_ON  = 2'h3;

  typedef enum logic [2:0] {
    PSW_SEL_CTRL,
    PSW_SEL_HYST1,
    PSW_SEL_HYST2,
    PSW_SEL_THR1,
    PSW_SEL_THR2,
    PSW_SEL_STATUS,
    PSW_SEL_DISPLAY,
    PSW_SEL_NONE
  } psw_sel_type;

  // address decode shared by the read and write paths
  function automatic psw_sel_type psw_decode(input logic [7:0] addr);
    unique case (addr)
      PSW_OFS_CTRL:    psw_decode = PSW_SEL_CTRL;
      PSW_OFS_HYST1:   psw_decode = PSW_SEL_HYST1;
      PSW_OFS_HYST2:   psw_decode = PSW_SEL_HYST2;
      PSW_OFS_THR1:    psw_decode = PSW_SEL_THR1;
      PSW_OFS_THR2:    psw_decode = PSW_SEL_THR2;
      PSW_OFS_STATUS:  psw_decode = PSW_SEL_STATUS;
      PSW_OFS_DISPLAY: psw_decode = PSW_SEL_DISPLAY;
      default:         psw_decode = PSW_SEL_NONE;
    endcase
  endfunction : psw_decode

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] psw_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    psw_merge = r;
  endfunction : psw_merge

endpackage : psw_pkg

// ==== psw_chan_if.sv ====
// carrier between the register block and one switching unit
`timescale 1ns/1ps
interface psw_chan_if;
  logic signed [31:0] value;
  logic signed [31:0] threshold;
  logic        [13:0] hyst;
  logic               less_mode;
  logic               dyn_mode;
  logic               sw_out;

  modport ctrl (output value, output threshold, output hyst,
                output less_mode, output dyn_mode, input sw_out);
  modport unit (input value, input threshold, input hyst,
                input less_mode, input dyn_mode, output sw_out);
endinterface : psw_chan_if

// ==== psw_switch_unit.sv ====
// one switching output: compare with hysteresis, static level or timed pulse
`timescale 1ns/1ps
module psw_switch_unit #(
  parameter int unsigned PULSE_CYCLES = psw_pkg::PSW_PULSE_CYCLES
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // channel settings and result
  psw_chan_if.unit  ch
);
  import psw_pkg::*;

  typedef struct packed {
    logic                   cond;
    logic                   sw_out;
    logic [PSW_TIMER_W-1:0] timer;
  } psw_unit_state_type;

  localparam psw_unit_state_type UNIT_RESET = '{default: '0};
  localparam logic [PSW_TIMER_W-1:0] PULSE_LAST =
    PSW_TIMER_W'(PULSE_CYCLES - 1);

  psw_unit_state_type q, d;
  logic signed [32:0] v_x;
  logic signed [32:0] thr_x;
  logic signed [32:0] hyst_x;
  logic               set_c;
  logic               rel_c;

  //////////////////////////////////////////////////////////////////////////
  // widened to 33 bits so threshold +/- hysteresis never wraps
  assign v_x    = 33'(ch.value);
  assign thr_x  = 33'(ch.threshold);
  assign hyst_x = $signed({19'h0_0000, ch.hyst});

  always_comb begin
    if (ch.less_mode) begin
      set_c = v_x < thr_x;
      rel_c = v_x >= thr_x + hyst_x;
    end else begin
      set_c = v_x >= thr_x;
      rel_c = v_x < thr_x - hyst_x;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.cond = q.cond ? !rel_c : set_c;
    if (!ch.dyn_mode) begin
      d.sw_out = d.cond;
      d.timer  = '0;
    end else if (d.cond && !q.cond && !q.sw_out) begin
      // pulse on entering the condition
      // an entry while a pulse runs is ignored, so length holds
      d.sw_out = 1'b1;
      d.timer  = PULSE_LAST;
    end else if (q.sw_out) begin
      // fixed pulse length, not restarted by an entry while it runs
      if (q.timer == '0) begin
        d.sw_out = 1'b0;
      end else begin
        d.timer = q.timer - 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= UNIT_RESET;
    end else begin
      q <= d;
    end
  end

  assign ch.sw_out = q.sw_out;

endmodule : psw_switch_unit

// ==== psw_top.sv ====
// preset switching outputs with an axi4-lite register slave
// Function
// - static level on at/above or below threshold
// - dynamic modes give timed pulse on entry
// - pulse length fixed at 500 ms
// - output 2 mirrors modes against threshold two
// - output 2 trailing mode: threshold one minus two
// - per-output hysteresis 0..9999, direction follows mode
// - thresholds default to 10000 and 5000
// - enter tap shows output states two seconds
// - report distinguishes four output state cases
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module psw_top #(
  parameter int unsigned PULSE_CYCLES  = psw_pkg::PSW_PULSE_CYCLES,
  parameter int unsigned REPORT_CYCLES = psw_pkg::PSW_REPORT_CYCLES
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  // axi4-lite write response
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  // axi4-lite read data
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // scaled display value and operator key
  input  wire logic [31:0] display_value,
  input  wire logic        enter_key,
  // switching outputs and state report
  output wire logic        output1,
  output wire logic        output2,
  output wire logic        report_active,
  output wire logic [1:0]  report_code
);
  import psw_pkg::*;

  typedef struct packed {
    logic [7:0]             aw_addr;
    logic                   aw_have;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   w_have;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [1:0]             output1_characteristic;
    logic [2:0]             output2_characteristic;
    logic [13:0]            output1_hysteresis;
    logic [13:0]            output2_hysteresis;
    logic [31:0]            threshold_one;
    logic [31:0]            threshold_two;
    logic                   key_s1;
    logic                   key_s2;
    logic                   key_prev;
    logic                   rep_active;
    logic [PSW_TIMER_W-1:0] rep_cnt;
    logic [1:0]             rep_code;
  } psw_top_state_type;

  localparam psw_top_state_type TOP_RESET = '{
    threshold_one:      PSW_THR1_RESET,
    threshold_two:      PSW_THR2_RESET,
    output1_hysteresis: PSW_HYST_RESET,
    output2_hysteresis: PSW_HYST_RESET,
    default:            '0
  };
  localparam logic [PSW_TIMER_W-1:0] REPORT_LAST =
    PSW_TIMER_W'(REPORT_CYCLES - 1);

  psw_top_state_type q, d;
  psw_chan_if        ch [2] ();
  logic [1:0]        sw_now;
  logic              trail;
  logic [31:0]       wv;
  logic [31:0]       status_w;

  //////////////////////////////////////////////////////////////////////////
  // switching units, one per output
  generate
    for (genvar i = 0; i < 2; i++) begin : g_unit
      psw_switch_unit #(
        .PULSE_CYCLES (PULSE_CYCLES)
      ) u_unit (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ch      (ch[i].unit)
      );
      assign ch[i].value = display_value;
      assign sw_now[i]   = ch[i].sw_out;
    end
  endgenerate

  assign ch[0].threshold = q.threshold_one;
  assign ch[0].hyst      = q.output1_hysteresis;
  assign ch[0].less_mode = q.output1_characteristic[0];
  assign ch[0].dyn_mode  = q.output1_characteristic[1];

  // trailing compares against threshold one minus threshold two
  assign trail = q.output2_characteristic[2];
  assign ch[1].threshold = trail ? q.threshold_one - q.threshold_two
                                 : q.threshold_two;
  // output 2 uses the same four modes on threshold two
  assign ch[1].hyst      = q.output2_hysteresis;
  assign ch[1].less_mode = trail ? 1'b0 : q.output2_characteristic[0];
  assign ch[1].dyn_mode  = trail ? q.output2_characteristic[0]
                                 : q.output2_characteristic[1];

  assign status_w = {26'h000_0000, q.rep_code, 1'b0, q.rep_active,
                     sw_now[1], sw_now[0]};

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    d  = q;
    wv = psw_merge(32'h0000_0000, q.w_data, q.w_strb);

    // address and data are latched independently, in either order
    if (s_axi_awvalid && !q.aw_have) begin
      d.aw_addr = s_axi_awaddr;
      d.aw_have = 1'b1;
    end
    if (s_axi_wvalid && !q.w_have) begin
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
      d.w_have = 1'b1;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = PSW_RESP_OKAY;
      unique case (psw_decode(q.aw_addr))
        PSW_SEL_CTRL: begin
          wv = psw_merge({25'h000_0000, q.output2_characteristic, 2'h0,
                          q.output1_characteristic}, q.w_data, q.w_strb);
          d.output1_characteristic = wv[PSW_CTRL_C1_LSB +: 2];
          // undefined characteristic codes leave output 2 unchanged
          if (wv[PSW_CTRL_C2_LSB +: 3] <= 3'(PSW_CHAR_TRAIL_DYN)) begin
            d.output2_characteristic = wv[PSW_CTRL_C2_LSB +: 3];
          end
        end
        PSW_SEL_HYST1: begin
          wv = psw_merge({18'h0_0000, q.output1_hysteresis}, q.w_data,
                         q.w_strb);
          d.output1_hysteresis = (wv > PSW_HYST_MAX) ?
            PSW_HYST_MAX[PSW_HYST_W-1:0] : wv[PSW_HYST_W-1:0];
        end
        PSW_SEL_HYST2: begin
          wv = psw_merge({18'h0_0000, q.output2_hysteresis}, q.w_data,
                         q.w_strb);
          d.output2_hysteresis = (wv > PSW_HYST_MAX) ?
            PSW_HYST_MAX[PSW_HYST_W-1:0] : wv[PSW_HYST_W-1:0];
        end
        PSW_SEL_THR1: begin
          d.threshold_one = psw_merge(q.threshold_one, q.w_data, q.w_strb);
        end
        PSW_SEL_THR2: begin
          d.threshold_two = psw_merge(q.threshold_two, q.w_data, q.w_strb);
        end
        PSW_SEL_STATUS, PSW_SEL_DISPLAY: begin
          // read-only words accept and drop the write
        end
        PSW_SEL_NONE: begin
          d.bresp = PSW_RESP_SLVERR;
        end
      endcase
    end

    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp  = PSW_RESP_OKAY;
      unique case (psw_decode(s_axi_araddr))
        PSW_SEL_CTRL: begin
          d.rdata = {25'h000_0000, q.output2_characteristic, 2'h0,
                     q.output1_characteristic};
        end
        PSW_SEL_HYST1:   d.rdata = {18'h0_0000, q.output1_hysteresis};
        PSW_SEL_HYST2:   d.rdata = {18'h0_0000, q.output2_hysteresis};
        PSW_SEL_THR1:    d.rdata = q.threshold_one;
        PSW_SEL_THR2:    d.rdata = q.threshold_two;
        PSW_SEL_STATUS:  d.rdata = status_w;
        PSW_SEL_DISPLAY: d.rdata = display_value;
        PSW_SEL_NONE: begin
          d.rdata = 32'h0000_0000;
          d.rresp = PSW_RESP_SLVERR;
        end
      endcase
    end

    // key pin is asynchronous: two stages before any logic looks at it
    d.key_s1   = enter_key;
    d.key_s2   = q.key_s1;
    d.key_prev = q.key_s2;

    // a tap starts or restarts the two second report
    if (q.key_s2 && !q.key_prev) begin
      d.rep_active = 1'b1;
      d.rep_cnt    = REPORT_LAST;
    end else if (q.rep_active) begin
      if (q.rep_cnt == '0) begin
        d.rep_active = 1'b0;
      end else begin
        d.rep_cnt = q.rep_cnt - 1'b1;
      end
    end

    // live code while shown, both-off code otherwise
    if (d.rep_active) begin
      unique case (sw_now)
        2'b00: d.rep_code = PSW_REP_BOTH_OFF;
        2'b01: d.rep_code = PSW_REP_ONLY_1;
        2'b10: d.rep_code = PSW_REP_ONLY_2;
        2'b11: d.rep_code = PSW_REP_BOTH_ON;
      endcase
    end else begin
      d.rep_code = PSW_REP_BOTH_OFF;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= TOP_RESET;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !q.aw_have;
  assign s_axi_wready  = !q.w_have;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign output1       = sw_now[0];
  assign output2       = sw_now[1];
  assign report_active = q.rep_active;
  assign report_code   = q.rep_code;

endmodule : psw_top

// ==== psw_props.sv ====
// concurrent checks on the preset switching outputs top ports
`timescale 1ns/1ps
module psw_props #(
  parameter int unsigned PULSE_CYCLES  = 8,
  parameter int unsigned REPORT_CYCLES = 20
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // key, outputs and report
  input wire logic        enter_key,
  input wire logic        output1,
  input wire logic        output2,
  input wire logic        report_active,
  input wire logic [1:0]  report_code
);
  import psw_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  property p_rep_zero;
    !report_active |-> report_code == PSW_REP_BOTH_OFF;
  endproperty
  a_rep_zero: assert property (p_rep_zero)
    else $error("report code set outside the window");
  // compare only once the outputs sat still, the code is registered
  property p_code;
    report_active && $past(report_active) && $stable({output2, output1})
      |-> report_code == {output2, output1};
  endproperty
  a_code: assert property (p_code)
    else $error("report code differs from output states");
  property p_key;
    $rose(enter_key) |-> ##[1:6] report_active;
  endproperty
  a_key: assert property (p_key)
    else $error("key tap gave no report");
  property p_rep_len;
    $rose(report_active) |-> report_active [*8];
  endproperty
  a_rep_len: assert property (p_rep_len)
    else $error("report window cut short");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped before taken");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped before taken");
  // one answer per read: data drop right after they are taken
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once)
    else $error("read answered twice");
  property p_ar_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_ans: assert property (p_ar_ans)
    else $error("read answer late");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == PSW_RESP_SLVERR |-> s_axi_rdata == '0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error read returned data");
  c_out1: cover property ($rose(output1));
  c_out2: cover property ($rose(output2));
  c_rep: cover property ($rose(report_active));
endmodule : psw_props

bind psw_top psw_props #(
  .PULSE_CYCLES  (PULSE_CYCLES),
  .REPORT_CYCLES (REPORT_CYCLES)
) chk_u (.*);

// ==== psw_machine.sv ====
// machinery model: measures how long each switching output stays on
`timescale 1ns/1ps
module psw_machine (
  // clock
  input  wire logic aclk,
  // switching outputs as wired to the machine
  input  wire logic output1,
  input  wire logic output2,
  // length of the last finished on period, in cycles
  output var  int   len1,
  output var  int   len2
);
  int run1 = 0;
  int run2 = 0;
  initial begin
    len1 = 0;
    len2 = 0;
  end
  always @(posedge aclk) begin
    run1 <= output1 ? run1 + 1 : 0;
    run2 <= output2 ? run2 + 1 : 0;
    if (!output1 && run1 != 0) len1 <= run1;
    if (!output2 && run2 != 0) len2 <= run2;
  end
endmodule : psw_machine

// ==== preset_switching_outputs_bench.sv ====
// self-checking bench for the preset switching outputs
`timescale 1ns/1ps
module preset_switching_outputs_bench;
  import psw_pkg::*;
  localparam int PUL = 8;
  localparam int RPT = 20;
  logic        aclk = 1'h0, aresetn = 1'h0, enter_key = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, display_value = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  // response readies stay high: every answer is taken at its first edge
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic        output1, output2, report_active;
  logic [1:0]  s_axi_bresp, s_axi_rresp, report_code;
  int          len1, len2, run, mismatches = 0, checks = 0;
  logic [33:0] rq[$], bq[$];
  logic [31:0] rs = 32'h0000_f559;

  psw_top #(.PULSE_CYCLES(PUL), .REPORT_CYCLES(RPT)) dut_u (.*);
  psw_machine mach_u (.*);
  always #5 aclk = ~aclk;
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  task automatic stop_test();
    $display("counts: checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic cmp(input string n, input logic [33:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic cmp_rd(input logic [33:0] e, g);
    cmp("read", e, g);
  endtask : cmp_rd

  task automatic cmp_wr(input logic [33:0] e, g);
    cmp("wresp", e, g);
  endtask : cmp_wr

  task automatic cmp_len(input string n, input logic [33:0] e, g);
    cmp(n, e, g);
  endtask : cmp_len

  task automatic guard(input int n);
    if (n >= 50) begin
      mismatches++;
      $display("CHECK FAILED bus wait expected answer seen none");
      stop_test();
    end
  endtask : guard

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int   n;
    logic aw_on;
    logic w_on;
    n     = 0;
    aw_on = 1'h1;
    w_on  = 1'h1;
    bq.push_back({r, 32'h0});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    // each channel released at its own handshake, then wait for bvalid
    do begin
      @(posedge aclk);
      n++;
      if (aw_on && s_axi_awready) begin
        aw_on = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w_on && s_axi_wready) begin
        w_on = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end while ((aw_on || w_on || !s_axi_bvalid) && n < 50);
    guard(n);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rq.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready && n++ < 50);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid && n++ < 50);
    guard(n);
  endtask : rd

  // result watcher: oldest note against each answer
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      cmp_rd(rq.size() ? rq.pop_front() : 'x, {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      cmp_wr(bq.size() ? bq.pop_front() : 'x, {s_axi_bresp, 32'h0});
    if (report_active) run <= run + 1;
    else if (run != 0) begin
      cmp_len("report length", 34'(RPT), 34'(run));
      run <= 0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] t1, t2, tr, v[6], cl[4], dv[4];
    logic [1:0]  cd[4];
    logic        e1, e2;
    logic [5:0]  hp;
    t1 = PSW_THR1_RESET;
    t2 = PSW_THR2_RESET;
    tr = t1 - 32'h0000_0bb8;
    run = 0;
    tick(6);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(PSW_OFS_THR1, {PSW_RESP_OKAY, t1});
    rd(PSW_OFS_THR2, {PSW_RESP_OKAY, t2});
    rd(PSW_OFS_HYST1, {PSW_RESP_OKAY, 32'h0});
    rd(8'h1c, {PSW_RESP_SLVERR, 32'h0});
    wr(8'h1c, 32'h0, PSW_RESP_SLVERR);
    $display("test reset done");
    v = '{t1, t1 - 1, t2, t2 - 1, xs() % 32'h0000_4e20, xs() % 32'h0000_4e20};
    for (int m = 0; m < 2; m++) begin
      wr(PSW_OFS_CTRL, m ? 32'h0000_0011 : 32'h0, PSW_RESP_OKAY);
      foreach (v[i]) begin
        display_value <= v[i];
        e1 = m ? v[i] < t1 : v[i] >= t1;
        e2 = m ? v[i] < t2 : v[i] >= t2;
        tick(2);
        rd(PSW_OFS_STATUS, {PSW_RESP_OKAY, 30'h0, e2, e1});
      end
    end
    $display("test static done");
    wr(PSW_OFS_CTRL, 32'h0, PSW_RESP_OKAY);
    wr(PSW_OFS_HYST1, 32'h0000_2ee0, PSW_RESP_OKAY);
    rd(PSW_OFS_HYST1, {PSW_RESP_OKAY, PSW_HYST_MAX});
    wr(PSW_OFS_HYST1, 32'h0000_0005, PSW_RESP_OKAY);
    v = '{t1, t1 - 5, t1 - 6, t1 - 1, t1, t1 - 6};
    // output 1 per step: on, held, released, not yet set, on, off
    hp = 6'b010011;
    foreach (v[i]) begin
      display_value <= v[i];
      tick(2);
      rd(PSW_OFS_STATUS, {PSW_RESP_OKAY, 30'h0, 1'h1, hp[i]});
    end
    $display("test hysteresis done");
    wr(PSW_OFS_THR2, 32'h0000_0bb8, PSW_RESP_OKAY);
    display_value <= 32'h0;
    wr(PSW_OFS_CTRL, 32'h0000_0052, PSW_RESP_OKAY);
    display_value <= t1;
    tick(PUL + 6);
    cmp_len("pulse 1", 34'(PUL), 34'(len1));
    cmp_len("pulse 2", 34'(PUL), 34'(len2));
    rd(PSW_OFS_STATUS, {PSW_RESP_OKAY, 32'h0});
    wr(PSW_OFS_CTRL, 32'h0000_0040, PSW_RESP_OKAY);
    display_value <= tr - 1;
    tick(2);
    rd(PSW_OFS_STATUS, {PSW_RESP_OKAY, 32'h0});
    display_value <= tr;
    tick(2);
    rd(PSW_OFS_STATUS, {PSW_RESP_OKAY, 32'h2});
    $display("test pulse and trailing done");
    cl = '{32'h0, 32'h0, 32'h0000_0010, 32'h0000_0010};
    dv = '{32'h0, t1, t1, 32'h0};
    cd = '{PSW_REP_BOTH_OFF, PSW_REP_BOTH_ON, PSW_REP_ONLY_1, PSW_REP_ONLY_2};
    for (int k = 0; k < 4; k++) begin
      wr(PSW_OFS_CTRL, cl[k], PSW_RESP_OKAY);
      display_value <= dv[k];
      tick(2);
      enter_key <= 1'h1;
      tick(4);
      enter_key <= 1'h0;
      rd(PSW_OFS_STATUS, {PSW_RESP_OKAY, 26'h0, cd[k], 2'h1, cd[k]});
      tick(RPT + 4);
    end
    $display("test report done");
    stop_test();
  end
endmodule : preset_switching_outputs_bench
